// ==== rtl/wss_defs.vh ====
// Register map, field positions, reset values and timing counts of the scan sequencer.
// Assumes a 125 MHz aclk and 32-bit AXI4-Lite register access.
`ifndef WSS_DEFS_VH
`define WSS_DEFS_VH

// Register byte offsets
`define WSS_CTRL_OFS      8'h00
`define WSS_RANGE_OFS     8'h04
`define WSS_STATUS_OFS    8'h08
`define WSS_IRQ_STAT_OFS  8'h0C
`define WSS_IRQ_MASK_OFS  8'h10
`define WSS_TEACH_OFS     8'h14
`define WSS_POS_OFS       8'h18

// Control fields
`define WSS_CTRL_DIR      0
`define WSS_CTRL_FREE     1
`define WSS_CTRL_FALLCLR  2
`define WSS_CTRL_TEACHMD  3
`define WSS_CTRL_RESET    32'h0000_0000

// Status fields
`define WSS_ST_GOOD       0
`define WSS_ST_FAULT      1
`define WSS_ST_BUSY       2
`define WSS_ST_HOMED      3

// Interrupt event bits
`define WSS_EV_GOOD       0
`define WSS_EV_FAULT      1
`define WSS_EV_HOMED      2
`define WSS_EV_TAUGHT     3

// Angle reset values and margins (same unit as wand position)
`define WSS_RANGE_START_RST 16'h0000
`define WSS_RANGE_END_RST   16'h0100
`define WSS_TEACH_BEYOND    16'h0020
`define WSS_DECEL_MARGIN    16'h0010

// Stall timeout: 10 ms at 8 ns
`define WSS_STALL_MS      10
`define WSS_CLK_NS        8
`define WSS_STALL_CYC     ((`WSS_STALL_MS * 1000000) / `WSS_CLK_NS)

`endif

// ==== rtl/wss_axil_slave.v ====
// AXI4-Lite slave handshake core: takes one write and one read at a time.
// Assumes the parent decodes addresses and supplies read data combinationally.
`default_nettype none
module wss_axil_slave (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // Write channels
    input  wire        awvalid,
    output wire        awready,
    input  wire [7:0]  awaddr,
    input  wire        wvalid,
    output wire        wready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    output reg         bvalid,
    input  wire        bready,
    output reg  [1:0]  bresp,
    // Read channels
    input  wire        arvalid,
    output wire        arready,
    input  wire [7:0]  araddr,
    output reg         rvalid,
    input  wire        rready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    // Register side
    output wire        wr_en,
    output reg  [7:0]  wr_addr,
    output reg  [31:0] wr_data,
    output reg  [3:0]  wr_strb,
    output wire        rd_en,
    output wire [7:0]  rd_addr,
    input  wire [31:0] rd_data,
    input  wire        wr_ok,
    input  wire        rd_ok
);
    reg aw_have_reg;
    reg w_have_reg;

    // Address and data may arrive in either order
    assign awready = ce && !aw_have_reg && !bvalid;
    assign wready  = ce && !w_have_reg && !bvalid;
    assign wr_en   = ce && aw_have_reg && w_have_reg && !bvalid;
    assign arready = ce && !rvalid;
    assign rd_en   = arvalid && arready;
    assign rd_addr = araddr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            wr_addr     <= 8'h00;
            wr_data     <= 32'h0000_0000;
            wr_strb     <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= 2'b00;
            rvalid      <= 1'b0;
            rdata       <= 32'h0000_0000;
            rresp       <= 2'b00;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_have_reg <= 1'b1;
                wr_addr     <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_reg <= 1'b1;
                wr_data    <= wdata;
                wr_strb    <= wstrb;
            end
            if (wr_en) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid      <= 1'b1;
                bresp       <= wr_ok ? 2'b00 : 2'b10;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (rd_en) begin
                rvalid <= 1'b1;
                rdata  <= rd_ok ? rd_data : 32'h0000_0000;
                rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // wss_axil_slave
`default_nettype wire

// ==== rtl/wss_sequencer.v ====
// Wand scan cycle sequencer: homing, teach and start cycles, result relays and LEDs.
// Assumes synchronous controller inputs and a signed-free wand angle from the feedback.
// Operation
// - Home wand to backstop at power-on
// - Teach: swivel to contact, store angle
// - Teach without contact: overshoot, return, fault
// - Good on contact in range, else fault; the code also gives good on a stall in range without contact
// - Fast approach, slow before range start
// - Stall or range end: return fast
// - Drive relay and LED matching result
// - Object mode: contact between start and end
// - Free mode: pass end without contact
// - Fault output at once, then return
// - Good shown only at stop position
// - Good: good relay only; else fault relay
// - Fault when wand cannot leave stop
// - Result latched until next cycle
// - Clear at next scan or start fall
`default_nettype none
`include "wss_defs.vh"
module wss_sequencer #(
    parameter TOOL_W    = 4,
    parameter ANG_W     = 16,
    parameter STALL_CYC = `WSS_STALL_CYC
) (
    // Clock, reset, enable
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              ce,
    // Controller inputs
    input  wire              start_in,
    input  wire              teach_in,
    input  wire [TOOL_W-1:0] tool_sel,
    // Wand feedback
    input  wire [ANG_W-1:0]  wand_angle,
    input  wire              wand_contact,
    input  wire              wand_at_stop,
    // Motor command
    output reg               motor_run,
    output reg               motor_dir_out,
    output reg               motor_fast,
    // Results
    output reg               good_relay,
    output reg               fault_result,
    output reg               good_led,
    output reg               fault_led,
    output wire              irq,
    // AXI4-Lite
    input  wire              s_axil_awvalid,
    output wire              s_axil_awready,
    input  wire [7:0]        s_axil_awaddr,
    input  wire              s_axil_wvalid,
    output wire              s_axil_wready,
    input  wire [31:0]       s_axil_wdata,
    input  wire [3:0]        s_axil_wstrb,
    output wire              s_axil_bvalid,
    input  wire              s_axil_bready,
    output wire [1:0]        s_axil_bresp,
    input  wire              s_axil_arvalid,
    output wire              s_axil_arready,
    input  wire [7:0]        s_axil_araddr,
    output wire              s_axil_rvalid,
    input  wire              s_axil_rready,
    output wire [31:0]       s_axil_rdata,
    output wire [1:0]        s_axil_rresp
);
    localparam NTOOL = 1 << TOOL_W;
    localparam [6:0] S_HOME = 7'b000_0001, S_IDLE = 7'b000_0010, S_LEAVE = 7'b000_0100,
                     S_FAST = 7'b000_1000, S_SCAN = 7'b001_0000, S_OVER = 7'b010_0000,
                     S_RET  = 7'b100_0000;

    reg [6:0]       state_reg;
    reg [31:0]      ctrl_reg;
    reg [ANG_W-1:0] range_start_angle;
    reg [ANG_W-1:0] range_end_angle;
    reg [ANG_W-1:0] teach_mem [0:NTOOL-1];
    reg [3:0]       irq_stat_reg;
    reg [3:0]       irq_mask_reg;
    reg [TOOL_W-1:0] tool_reg;
    reg             teaching_reg;
    reg             pend_good_reg;
    reg             homed_reg;
    reg             start_d_reg;
    reg             teach_d_reg;
    reg [31:0]      stall_cnt_reg;
    reg [ANG_W-1:0] last_angle_reg;
    reg [3:0]       ev_reg;
    integer         i;
    wire        wr_en, rd_en;
    wire [7:0]  wr_addr, rd_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    reg  [31:0] rd_data;
    reg         rd_ok;
    wire        wr_ok = (wr_addr <= `WSS_TEACH_OFS) && (wr_addr != `WSS_STATUS_OFS);

    function [ANG_W-1:0] sat_add;
        input [ANG_W-1:0] a;
        input [ANG_W-1:0] b;
        reg   [ANG_W:0]   s;
        begin
            s = {1'b0, a} + {1'b0, b};
            sat_add = s[ANG_W] ? {ANG_W{1'b1}} : s[ANG_W-1:0];
        end
    endfunction

    function [ANG_W-1:0] sat_sub;
        input [ANG_W-1:0] a;
        input [ANG_W-1:0] b;
        begin
            sat_sub = (a > b) ? a - b : {ANG_W{1'b0}};
        end
    endfunction
    wire free_mode = ctrl_reg[`WSS_CTRL_FREE];
    wire [ANG_W-1:0] taught = teach_mem[tool_reg];
    // Teach mode: window around the learned angle; switch mode: rotary range
    wire [ANG_W-1:0] win_lo = ctrl_reg[`WSS_CTRL_TEACHMD] ?
                              sat_sub(taught, `WSS_DECEL_MARGIN) : range_start_angle;
    wire [ANG_W-1:0] win_hi = ctrl_reg[`WSS_CTRL_TEACHMD] ?
                              sat_add(taught, `WSS_DECEL_MARGIN) : range_end_angle;
    wire [ANG_W-1:0] teach_lim = sat_add(range_end_angle, `WSS_TEACH_BEYOND);
    wire start_rise = start_in && !start_d_reg;
    wire start_fall = !start_in && start_d_reg;
    wire teach_rise = teach_in && !teach_d_reg;
    // Stall is no progress in angle for the timeout; contact counts separately
    wire stalled = (stall_cnt_reg >= STALL_CYC - 1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg         <= S_HOME;
            ctrl_reg          <= `WSS_CTRL_RESET;
            range_start_angle <= `WSS_RANGE_START_RST;
            range_end_angle   <= `WSS_RANGE_END_RST;
            irq_stat_reg      <= 4'h0;
            irq_mask_reg      <= 4'h0;
            tool_reg          <= {TOOL_W{1'b0}};
            teaching_reg      <= 1'b0;
            pend_good_reg     <= 1'b0;
            homed_reg         <= 1'b0;
            start_d_reg       <= 1'b0;
            teach_d_reg       <= 1'b0;
            stall_cnt_reg     <= 32'h0000_0000;
            last_angle_reg    <= {ANG_W{1'b0}};
            ev_reg            <= 4'h0;
            motor_run         <= 1'b0;
            motor_dir_out     <= 1'b0;
            motor_fast        <= 1'b0;
            good_relay        <= 1'b0;
            fault_result      <= 1'b1;
            good_led          <= 1'b0;
            fault_led         <= 1'b1;
            for (i = 0; i < NTOOL; i = i + 1)
                teach_mem[i] <= {ANG_W{1'b0}};
        end else if (ce) begin
            ev_reg <= 4'h0;
            start_d_reg <= start_in;
            teach_d_reg <= teach_in;
            last_angle_reg <= wand_angle;
            if (!motor_run || wand_angle != last_angle_reg)
                stall_cnt_reg <= 32'h0000_0000;
            else if (!stalled)
                stall_cnt_reg <= stall_cnt_reg + 32'h0000_0001;
            if (start_fall && ctrl_reg[`WSS_CTRL_FALLCLR]) begin
                good_relay   <= 1'b0;
                good_led     <= 1'b0;
                fault_result <= 1'b1;
            end
            case (state_reg)
                S_HOME: begin
                    motor_run     <= 1'b1;
                    motor_fast    <= 1'b1;
                    motor_dir_out <= ~ctrl_reg[`WSS_CTRL_DIR];
                    if (wand_at_stop || stalled) begin
                        motor_run <= 1'b0;
                        homed_reg <= 1'b1;
                        ev_reg[`WSS_EV_HOMED] <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    motor_run <= 1'b0;
                    // Pulses only taken here, so a running cycle ignores them
                    if (start_rise || teach_rise) begin
                        tool_reg      <= tool_sel;
                        teaching_reg  <= teach_rise && !start_rise;
                        pend_good_reg <= 1'b0;
                        if (!ctrl_reg[`WSS_CTRL_FALLCLR]) begin
                            good_relay   <= 1'b0;
                            good_led     <= 1'b0;
                            fault_result <= 1'b1;
                        end
                        fault_led    <= 1'b0;
                        motor_run     <= 1'b1;
                        motor_fast    <= 1'b1;
                        motor_dir_out <= ctrl_reg[`WSS_CTRL_DIR];
                        state_reg     <= S_LEAVE;
                    end
                end
                S_LEAVE: begin
                    if (!wand_at_stop)
                        state_reg <= teaching_reg ? S_SCAN : S_FAST;
                    else if (stalled || wand_contact) begin
                        fault_result <= 1'b1;
                        fault_led    <= 1'b1;
                        ev_reg[`WSS_EV_FAULT] <= 1'b1;
                        state_reg    <= S_RET;
                    end
                end
                S_FAST: begin
                    if (wand_contact || stalled) begin
                        fault_led <= 1'b1;
                        ev_reg[`WSS_EV_FAULT] <= 1'b1;
                        state_reg <= S_RET;
                    end else if (wand_angle >= sat_sub(win_lo, `WSS_DECEL_MARGIN)) begin
                        motor_fast <= 1'b0;
                        state_reg  <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    motor_fast <= teaching_reg;
                    if (teaching_reg) begin
                        if (wand_contact) begin
                            teach_mem[tool_reg] <= wand_angle;
                            ev_reg[`WSS_EV_TAUGHT] <= 1'b1;
                            pend_good_reg <= 1'b1;
                            state_reg <= S_RET;
                        end else if (wand_angle >= teach_lim || stalled) begin
                            state_reg <= S_OVER;
                        end
                    end else if (wand_contact || stalled) begin
                        if (!free_mode && wand_angle > win_lo && wand_angle < win_hi) begin
                            pend_good_reg <= 1'b1;
                        end else begin
                            fault_led <= 1'b1;
                            ev_reg[`WSS_EV_FAULT] <= 1'b1;
                        end
                        state_reg <= S_RET;
                    end else if (wand_angle > win_hi) begin
                        if (free_mode) begin
                            pend_good_reg <= 1'b1;
                        end else begin
                            fault_led <= 1'b1;
                            ev_reg[`WSS_EV_FAULT] <= 1'b1;
                        end
                        state_reg <= S_RET;
                    end
                end
                S_OVER: begin
                    fault_led <= 1'b1;
                    ev_reg[`WSS_EV_FAULT] <= 1'b1;
                    state_reg <= S_RET;
                end
                S_RET: begin
                    motor_dir_out <= ~ctrl_reg[`WSS_CTRL_DIR];
                    motor_fast    <= 1'b1;
                    if (wand_at_stop || stalled) begin
                        motor_run <= 1'b0;
                        if (pend_good_reg && wand_at_stop) begin
                            good_relay   <= 1'b1;
                            good_led     <= 1'b1;
                            fault_result <= 1'b0;
                            fault_led    <= 1'b0;
                            ev_reg[`WSS_EV_GOOD] <= 1'b1;
                        end else begin
                            fault_led <= 1'b1;
                        end
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_HOME;
            endcase
            // Register writes; status events win over a write-one clear
            if (wr_en && wr_addr == `WSS_CTRL_OFS && wr_strb[0]) begin
                if (wr_data[`WSS_CTRL_DIR] != ctrl_reg[`WSS_CTRL_DIR] && state_reg == S_IDLE)
                    state_reg <= S_HOME; // New direction re-homes the wand when written in S_IDLE
                ctrl_reg <= {28'h000_0000, wr_data[3:0]};
            end
            if (wr_en && wr_addr == `WSS_RANGE_OFS && wr_data[15:0] < wr_data[31:16])
                {range_end_angle, range_start_angle} <= wr_data;
            if (wr_en && wr_addr == `WSS_IRQ_MASK_OFS)
                irq_mask_reg <= wr_data[3:0];
            if (wr_en && wr_addr == `WSS_TEACH_OFS)
                teach_mem[wr_data[16+TOOL_W-1:16]] <= wr_data[ANG_W-1:0];
            if (wr_en && wr_addr == `WSS_IRQ_STAT_OFS)
                irq_stat_reg <= (irq_stat_reg & ~wr_data[3:0]) | ev_reg;
            else
                irq_stat_reg <= irq_stat_reg | ev_reg;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    always @* begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `WSS_CTRL_OFS:     rd_data = ctrl_reg;
            `WSS_RANGE_OFS:    rd_data = {range_end_angle, range_start_angle};
            `WSS_STATUS_OFS:   rd_data = {21'h00_0000, state_reg, homed_reg,
                                          state_reg != S_IDLE, fault_result, good_relay};
            `WSS_IRQ_STAT_OFS: rd_data = {28'h000_0000, irq_stat_reg};
            `WSS_IRQ_MASK_OFS: rd_data = {28'h000_0000, irq_mask_reg};
            `WSS_TEACH_OFS:    rd_data = {{(16-TOOL_W){1'b0}}, tool_reg, taught};
            `WSS_POS_OFS:      rd_data = {16'h0000, wand_angle};
            default:           rd_ok = 1'b0;
        endcase
    end

    wss_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .awvalid (s_axil_awvalid),
        .awready (s_axil_awready),
        .awaddr  (s_axil_awaddr),
        .wvalid  (s_axil_wvalid),
        .wready  (s_axil_wready),
        .wdata   (s_axil_wdata),
        .wstrb   (s_axil_wstrb),
        .bvalid  (s_axil_bvalid),
        .bready  (s_axil_bready),
        .bresp   (s_axil_bresp),
        .arvalid (s_axil_arvalid),
        .arready (s_axil_arready),
        .araddr  (s_axil_araddr),
        .rvalid  (s_axil_rvalid),
        .rready  (s_axil_rready),
        .rdata   (s_axil_rdata),
        .rresp   (s_axil_rresp),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr_ok   (wr_ok),
        .rd_ok   (rd_ok)
    );
endmodule // wss_sequencer
`default_nettype wire

// ==== verification/wss_sequencer_monitor.sv ====
// Checker on the sequencer ports: relays, LEDs, motor command timing.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module wss_sequencer_monitor #(
    parameter STALL_CYC = 20
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Controller and wand
    input wire logic        start_in,
    input wire logic [15:0] wand_angle,
    input wire logic        wand_at_stop,
    // Motor and results
    input wire logic        motor_run,
    input wire logic        motor_dir_out,
    input wire logic        motor_fast,
    input wire logic        good_relay,
    input wire logic        fault_result,
    input wire logic        good_led,
    input wire logic        fault_led
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] still_cnt;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Running cycles on a frozen wand; a fresh run restarts the count
    always @(posedge aclk) begin
        if (!aresetn || !$stable(wand_angle) || (motor_run && !$past(motor_run)))
            still_cnt <= 32'h0000_0000;
        else if (motor_run && still_cnt < 32'h0000_03e8)
            still_cnt <= still_cnt + 32'h0000_0001;
    end
    a_relay_excl: assert property (good_relay != fault_result)
        else $error("relays not exclusive");
    a_led_match: assert property (good_led == good_relay && (!fault_led || fault_result))
        else $error("leds disagree with relays");
    a_good_at_stop: assert property ($rose(good_relay) |-> $past(wand_at_stop))
        else $error("good shown away from stop");
    a_start_runs: assert property ($rose(start_in) && !motor_run && wand_at_stop
        |=> motor_run && motor_fast) else $error("start did not launch fast run");
    a_fast_return: assert property ($past(motor_run) && motor_run && $changed(motor_dir_out)
        |-> motor_fast) else $error("reversal not at full speed");
    a_result_hold: assert property ($fell(good_relay) |-> motor_run || !start_in)
        else $error("result dropped without new cycle");
    a_fault_return: assert property ($rose(fault_led) |-> ##[0:2] (!motor_run || motor_fast))
        else $error("no fast return after fault");
    a_stall_fault: assert property (still_cnt == STALL_CYC - 2 |-> ##[0:8] fault_led)
        else $error("stalled wand gave no fault");
endmodule // wss_sequencer_monitor
bind wss_sequencer wss_sequencer_monitor #(.STALL_CYC(STALL_CYC)) i_monitor (
    .aclk(aclk), .aresetn(aresetn), .start_in(start_in), .wand_angle(wand_angle),
    .wand_at_stop(wand_at_stop), .motor_run(motor_run), .motor_dir_out(motor_dir_out),
    .motor_fast(motor_fast), .good_relay(good_relay), .fault_result(fault_result),
    .good_led(good_led), .fault_led(fault_led));
`default_nettype wire

// ==== verification/wss_wand_model.sv ====
// Wand mechanics: integrates motor commands into an angle, backstop at 0.
// Assumes motor_dir_out low (direction bit clear) means outward; the bench places the object.
`default_nettype none
module wss_wand_model (
    // Clock
    input wire logic        aclk,
    // Motor command
    input wire logic        motor_run,
    input wire logic        motor_dir_out,
    input wire logic        motor_fast,
    // Scene
    input wire logic        stuck,
    input wire logic [15:0] obj_angle,
    // Feedback
    output var logic [15:0] wand_angle,
    output logic            wand_contact,
    output logic            wand_at_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] step;
    assign step = motor_fast ? 16'h0004 : 16'h0001;
    // Starts away from the stop so that homing really moves
    initial wand_angle = 16'h0028;
    // The object blocks travel; a stuck wand ignores the motor
    always @(posedge aclk) begin
        if (motor_run && !stuck && !motor_dir_out)
            wand_angle <= (wand_angle + step >= obj_angle) ? obj_angle : wand_angle + step;
        else if (motor_run && !stuck)
            wand_angle <= (wand_angle > step) ? wand_angle - step : 16'h0000;
    end
    assign wand_contact = (wand_angle == obj_angle);
    assign wand_at_stop = (wand_angle == 16'h0000);
endmodule // wss_wand_model
`default_nettype wire

// ==== verification/test_wand_scan_cycle_sequencer.sv ====
// Testbench: bus tasks, scan scenes, result notes checked by a watcher.
// Assumes the wand model and the bound checker in their own files.
`default_nettype none
module test_wand_scan_cycle_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 0, aresetn = 0, start_in = 0, teach_in = 0, stuck = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq, irq_a;
    logic        wand_contact, wand_at_stop, motor_run, motor_dir_out, motor_fast;
    logic        good_relay, fault_result, good_led, fault_led, watch = 0, run_q = 0;
    logic [3:0]  tool_sel = 4'h0, wstrb = 4'h0;
    logic [15:0] obj_angle = 16'hffff, wand_angle;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, v;
    logic [1:0]  bresp, rresp;
    logic [3:0]  exp_q[$];
    int          failures = 0, cmp_count = 0, cyc = 0;
    wss_sequencer #(.STALL_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .start_in(start_in), .teach_in(teach_in), .tool_sel(tool_sel),
        .wand_angle(wand_angle), .wand_contact(wand_contact), .wand_at_stop(wand_at_stop),
        .motor_run(motor_run), .motor_dir_out(motor_dir_out), .motor_fast(motor_fast),
        .good_relay(good_relay), .fault_result(fault_result), .good_led(good_led),
        .fault_led(fault_led), .irq(irq), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_awaddr(awaddr), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_bresp(bresp), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_araddr(araddr), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .s_axil_rdata(rdata), .s_axil_rresp(rresp));
    wss_wand_model i_wand (.aclk(aclk), .motor_run(motor_run), .motor_dir_out(motor_dir_out),
        .motor_fast(motor_fast), .stuck(stuck), .obj_angle(obj_angle),
        .wand_angle(wand_angle), .wand_contact(wand_contact), .wand_at_stop(wand_at_stop));
    always #4 aclk = ~aclk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= 4'hf; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge aclk);
        chk("write response", bresp, resp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] resp);
        arvalid <= 1; araddr <= a; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        v = rdata;
        chk("read response", rresp, resp);
    endtask
    // One cycle with a note of its result; a teach pulse mid-run must be ignored
    task automatic scan(input logic tch, input logic [15:0] obj, input logic [3:0] want,
                        input logic hold);
        obj_angle <= obj;
        tool_sel <= 4'($urandom);
        exp_q.push_back(want);
        @(posedge aclk);
        if (tch) teach_in <= 1;
        else start_in <= 1;
        repeat (3) @(posedge aclk);
        teach_in <= 0; start_in <= hold;
        repeat (2) @(posedge aclk);
        teach_in <= 1;
        @(posedge aclk);
        teach_in <= 0;
        while (motor_run) @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask
    // Result appears when the run ends: {good, fault relay, good LED, fault LED}
    always @(posedge aclk) begin
        run_q <= motor_run;
        cyc <= cyc + 1;
        if (watch && run_q && !motor_run) begin
            if (exp_q.size() == 0) chk("spurious result", 1, 0);
            else chk("result", {good_relay, fault_result, good_led, fault_led}, exp_q.pop_front());
        end
        if (cyc == 40000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hfdf9_ef4a));
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(8'h00, 2'b00); chk("ctrl reset", v, 32'h0000_0000);
        rd(8'h04, 2'b00); chk("range reset", v, 32'h0100_0000);
        rd(8'h1c, 2'b10); chk("unmapped data", v, 32'h0000_0000);
        wr(8'h08, 32'h0000_0001, 2'b10);
        wr(8'h18, 32'h0000_0001, 2'b10);
        while (!wand_at_stop || motor_run) @(posedge aclk);
        rd(8'h08, 2'b00); chk("homed", v[3], 1'b1);
        wr(8'h04, 32'h00c0_0020, 2'b00);
        watch = 1;
        repeat (4) scan(0, 16'h0040 + 16'($urandom % 96), 4'b1010, 0);
        scan(0, 16'h0018, 4'b0101, 0);
        scan(0, 16'hffff, 4'b0101, 0);
        stuck <= 1;
        scan(0, 16'hffff, 4'b0101, 0);
        stuck <= 0;
        wr(8'h10, 32'h0000_0000, 2'b00); irq_a = irq;
        wr(8'h10, 32'h0000_000f, 2'b00); chk("irq mask", irq_a ^ irq, 1'b1);
        wr(8'h0c, 32'h0000_000f, 2'b00); chk("irq cleared", irq, 1'b0);
        wr(8'h10, 32'h0000_0000, 2'b00); chk("irq cleared", irq, 1'b0);
        scan(1, 16'h0050, 4'b1010, 0);
        rd(8'h14, 2'b00); chk("taught angle", v[15:0], 16'h0050);
        scan(1, 16'hffff, 4'b0101, 0);
        wr(8'h00, 32'h0000_0002, 2'b00);
        scan(0, 16'hffff, 4'b1010, 0);
        scan(0, 16'h0080, 4'b0101, 0);
        wr(8'h00, 32'h0000_0004, 2'b00);
        scan(0, 16'h0070, 4'b1010, 1);
        repeat (20) @(posedge aclk);
        chk("held result", {good_relay, fault_result}, 2'b10);
        start_in <= 0;
        repeat (4) @(posedge aclk);
        chk("cleared on start fall", {good_relay, fault_result}, 2'b01);
        conclude();
    end
endmodule // test_wand_scan_cycle_sequencer
`default_nettype wire
